// ### logic/csb_pkg.sv
package csb_pkg;

  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // program counter width, pc and flag reset values
  localparam int        PC_W_DEF  = 9;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET = 8'h00;

  // bus register byte offsets
  localparam logic [3:0] OFS_FLAGS = 4'h0;
  localparam logic [3:0] OFS_PC    = 4'h4;
  localparam logic [3:0] OFS_DIFF  = 4'h8;
  localparam logic [3:0] OFS_INFO  = 4'hc;

  // info register field positions
  localparam int INFO_CYCLES_LSB = 0;
  localparam int INFO_SKIP       = 2;
  localparam int INFO_TAKEN      = 3;

  // cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  typedef enum logic [4:0] {
    op_none,
    compare_regs,
    compare_regs_with_carry,
    compare_immediate,
    skip_if_reg_bit_clear,
    skip_if_reg_bit_set,
    skip_if_io_bit_clear,
    skip_if_io_bit_set,
    branch_if_status_bit_set,
    branch_if_status_bit_clear,
    branch_if_equal,
    branch_if_not_equal,
    branch_if_carry_set,
    branch_if_carry_clear,
    branch_if_same_or_higher,
    branch_if_lower,
    branch_if_minus,
    branch_if_plus,
    branch_if_signed_ge,
    branch_if_signed_lt,
    branch_if_half_carry_set,
    branch_if_half_carry_clear,
    branch_if_transfer_bit_set,
    branch_if_transfer_bit_clear,
    branch_if_overflow_set,
    branch_if_overflow_clear
  } opcode_t;

  typedef struct packed {
    opcode_t    code;
    logic [7:0] first;
    logic [7:0] second;
    logic [7:0] immediate;
    logic [2:0] bit_sel;
    logic [7:0] io_value;
    logic [6:0] offset;
    logic       next_two_word;
  } op_t;

endpackage

// ### logic/sub_flags.sv
`timescale 1ns/10ps
`default_nettype none
module sub_flags
(
  input  wire logic       i_a,
  input  wire logic       i_b,
  input  wire logic       i_cin,
  output logic            o_diff,
  output logic            o_borrow
);
  assign o_diff   = i_a ^ i_b ^ i_cin;
  assign o_borrow = (~i_a & i_b) | (~i_a & i_cin) | (i_b & i_cin);
endmodule
`default_nettype wire

// ### logic/compare_skip_branch_unit.sv
// Notes on behaviour
// - register compare subtracts, sets five flags, one cycle
// - compare with carry also subtracts carry flag
// - compare immediate subtracts constant, one cycle
// - skip on clear register bit, flags kept
// - skip on set register bit, flags kept
// - skip on clear io bit, flags kept
// - skip on set io bit, flags kept
// - branch on set status bit, pc+k+1
// - branch on clear status bit, pc+k+1
// - branch if equal uses zero set
// - branch if not equal uses zero clear
// - carry set and lower branch on carry
// - carry clear and same-or-higher on no carry
// - minus branches when negative set
// - plus branches when negative clear
// - signed ge when negative xor overflow clear
// - signed lt when negative xor overflow set
// - half carry branches on set or clear
// - transfer bit branches on set or clear
// - overflow branches on set or clear
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
module compare_skip_branch_unit
#(
  parameter int PC_W = csb_pkg::PC_W_DEF
)
(
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  input  wire logic             i_op_valid,
  input  wire csb_pkg::op_t     i_op,
  output logic                  o_op_ready,
  output logic                  o_done,
  output logic                  o_skip,
  output logic                  o_taken,
  output logic [PC_W-1:0]       o_pc,
  output logic [7:0]            o_flags,
  input  wire logic [3:0]       i_address,
  input  wire logic             i_read,
  input  wire logic             i_write,
  input  wire logic [31:0]      i_writedata,
  input  wire logic [3:0]       i_byteenable,
  output logic [31:0]           o_readdata,
  output logic                  o_waitrequest
);
  import csb_pkg::*;

  logic [7:0]      diff;
  logic [8:0]      borrow;
  logic [7:0]      sub_b;
  logic            sub_cin;
  logic            is_compare;
  logic            take;
  logic            bus_take;
  logic            bus_wr;
  logic [1:0]      count;
  logic [7:0]      last_diff;
  logic [1:0]      last_cycles;
  logic            last_skip;
  logic            last_taken;
  logic [PC_W-1:0] next_pc;
  logic [7:0]      next_flags;
  logic [1:0]      next_cycles;
  logic            next_skip;
  logic            next_taken;
  logic            branch_cond;
  logic            is_branch;
  logic            is_skip;
  logic            skip_cond;
  logic [PC_W-1:0] rel_offset;
  logic            bus_req;
  logic            rd_first;
  logic            flags_wr;
  logic            pc_wr_lo;
  logic            pc_wr_hi;
  logic            sub_ovf;
  logic            skip_hit;
  logic            branch_hit;
  logic [31:0]     info_word;
  logic [31:0]     read_word;

  assign take     = i_op_valid & o_op_ready;
  assign bus_req  = i_read | i_write;
  assign bus_take = bus_req & ~o_waitrequest;
  assign bus_wr   = bus_take & i_write;
  assign rd_first = i_read & o_waitrequest;

  // bus write decode; byte lanes gate each field
  always_comb
  begin
    flags_wr = 1'b0;
    pc_wr_lo = 1'b0;
    pc_wr_hi = 1'b0;
    if (bus_wr)
    begin
      case (i_address)
        OFS_FLAGS: flags_wr = i_byteenable[0];
        OFS_PC:
        begin
          pc_wr_lo = i_byteenable[0];
          pc_wr_hi = i_byteenable[1];
        end
        default:   flags_wr = 1'b0;
      endcase
    end
  end

  // subtraction operands
  always_comb
  begin
    is_compare = (i_op.code == compare_regs) | (i_op.code == compare_regs_with_carry)
               | (i_op.code == compare_immediate);
    sub_b   = (i_op.code == compare_immediate) ? i_op.immediate : i_op.second;
    sub_cin = (i_op.code == compare_regs_with_carry) & o_flags[FLAG_C];
  end

  assign borrow[0] = sub_cin;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_sub
      sub_flags u_bit
      (
        .i_a      (i_op.first[g]),
        .i_b      (sub_b[g]),
        .i_cin    (borrow[g]),
        .o_diff   (diff[g]),
        .o_borrow (borrow[g+1])
      );
    end
  endgenerate

  // branch condition select
  always_comb
  begin
    is_branch   = 1'b1;
    branch_cond = 1'b0;
    case (i_op.code)
      branch_if_status_bit_set:     branch_cond = o_flags[i_op.bit_sel];
      branch_if_status_bit_clear:   branch_cond = ~o_flags[i_op.bit_sel];
      branch_if_equal:              branch_cond = o_flags[FLAG_Z];
      branch_if_not_equal:          branch_cond = ~o_flags[FLAG_Z];
      branch_if_carry_set:          branch_cond = o_flags[FLAG_C];
      branch_if_lower:              branch_cond = o_flags[FLAG_C];
      branch_if_carry_clear:        branch_cond = ~o_flags[FLAG_C];
      branch_if_same_or_higher:     branch_cond = ~o_flags[FLAG_C];
      branch_if_minus:              branch_cond = o_flags[FLAG_N];
      branch_if_plus:               branch_cond = ~o_flags[FLAG_N];
      branch_if_signed_ge:
        branch_cond = ~(o_flags[FLAG_N] ^ o_flags[FLAG_V]);
      branch_if_signed_lt:
        branch_cond = o_flags[FLAG_N] ^ o_flags[FLAG_V];
      branch_if_half_carry_set:     branch_cond = o_flags[FLAG_H];
      branch_if_half_carry_clear:   branch_cond = ~o_flags[FLAG_H];
      branch_if_transfer_bit_set:   branch_cond = o_flags[FLAG_T];
      branch_if_transfer_bit_clear: branch_cond = ~o_flags[FLAG_T];
      branch_if_overflow_set:       branch_cond = o_flags[FLAG_V];
      branch_if_overflow_clear:     branch_cond = ~o_flags[FLAG_V];
      default:                      is_branch   = 1'b0;
    endcase
  end

  // skip condition select
  always_comb
  begin
    is_skip   = 1'b1;
    skip_cond = 1'b0;
    case (i_op.code)
      skip_if_reg_bit_clear: skip_cond = ~i_op.first[i_op.bit_sel];
      skip_if_reg_bit_set:   skip_cond = i_op.first[i_op.bit_sel];
      skip_if_io_bit_clear:  skip_cond = ~i_op.io_value[i_op.bit_sel];
      skip_if_io_bit_set:    skip_cond = i_op.io_value[i_op.bit_sel];
      default:               is_skip   = 1'b0;
    endcase
  end

  assign rel_offset = {{(PC_W-7){i_op.offset[6]}}, i_op.offset};
  assign skip_hit   = is_skip & skip_cond;
  assign branch_hit = is_branch & branch_cond;

  // signed overflow of the subtraction
  assign sub_ovf = (i_op.first[7] & ~sub_b[7] & ~diff[7])
                 | (~i_op.first[7] & sub_b[7] & diff[7]);

  // next program counter, cycle count and flags
  always_comb
  begin
    next_pc     = o_pc + PC_W'(1);
    next_cycles = CYC_ONE;
    next_skip   = 1'b0;
    next_taken  = 1'b0;
    next_flags  = o_flags;
    if (is_compare)
    begin
      next_flags[FLAG_Z] = (diff == 8'h00);
      next_flags[FLAG_N] = diff[7];
      next_flags[FLAG_V] = sub_ovf;
      next_flags[FLAG_C] = borrow[8];
      next_flags[FLAG_H] = borrow[4];
    end
    else if (skip_hit)
    begin
      next_skip = 1'b1;
      if (i_op.next_two_word)
      begin
        next_pc     = o_pc + PC_W'(3);
        next_cycles = CYC_THREE;
      end
      else
      begin
        next_pc     = o_pc + PC_W'(2);
        next_cycles = CYC_TWO;
      end
    end
    else if (branch_hit)
    begin
      next_taken  = 1'b1;
      next_pc     = o_pc + rel_offset + PC_W'(1);
      next_cycles = CYC_TWO;
    end
  end

  // program counter; execution wins over a bus write
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      o_pc <= PC_W'(PC_RESET);
    else if (take)
      o_pc <= next_pc;
    else
    begin
      if (pc_wr_lo)
        o_pc[7:0] <= i_writedata[7:0];
      if (pc_wr_hi)
        o_pc[PC_W-1:8] <= i_writedata[PC_W-1:8];
    end
  end

  // status flags; compares and bus writes change them, execution wins
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      o_flags <= FLAGS_RESET;
    else if (take)
      o_flags <= next_flags;
    else if (flags_wr)
      o_flags <= i_writedata[7:0];
  end

  // cycle counter and ready
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      count      <= 2'h0;
      o_op_ready <= 1'b0;
      o_done     <= 1'b0;
    end
    else if (take)
    begin
      count      <= next_cycles - CYC_ONE;
      o_op_ready <= (next_cycles == CYC_ONE);
      o_done     <= (next_cycles == CYC_ONE);
    end
    else if (count != 2'h0)
    begin
      count      <= count - 2'h1;
      o_op_ready <= (count == 2'h1);
      o_done     <= (count == 2'h1);
    end
    else
    begin
      o_op_ready <= 1'b1;
      o_done     <= 1'b0;
    end
  end

  // result of the last instruction
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
    begin
      o_skip      <= 1'b0;
      o_taken     <= 1'b0;
      last_cycles <= 2'h0;
      last_diff   <= 8'h00;
    end
    else if (take)
    begin
      o_skip      <= next_skip;
      o_taken     <= next_taken;
      last_cycles <= next_cycles;
      if (is_compare)
        last_diff <= diff;
    end
  end

  assign last_skip  = o_skip;
  assign last_taken = o_taken;

  // info word from the last instruction
  always_comb
  begin
    info_word                      = 32'h00000000;
    info_word[INFO_CYCLES_LSB +: 2] = last_cycles;
    info_word[INFO_SKIP]            = last_skip;
    info_word[INFO_TAKEN]           = last_taken;
  end

  // read data select
  always_comb
  begin
    case (i_address)
      OFS_FLAGS: read_word = {24'h000000, o_flags};
      OFS_PC:    read_word = {{(32-PC_W){1'b0}}, o_pc};
      OFS_DIFF:  read_word = {24'h000000, last_diff};
      OFS_INFO:  read_word = info_word;
      default:   read_word = 32'h00000000;
    endcase
  end

  // bus handshake: one wait cycle, then the answer
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      o_waitrequest <= 1'b1;
    else if (bus_req & o_waitrequest)
      o_waitrequest <= 1'b0;
    else
      o_waitrequest <= 1'b1;
  end

  // read data
  always_ff @(posedge i_mclk)
  begin
    if (!i_nrst)
      o_readdata <= 32'h00000000;
    else if (rd_first)
      o_readdata <= read_word;
  end

endmodule
`default_nettype wire

// ### bench/csb_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module csb_assertions
#(
  parameter int PC_W = 9
)
(
  input  wire logic            i_mclk,
  input  wire logic            i_nrst,
  input  wire logic            i_op_valid,
  input  wire csb_pkg::op_t    i_op,
  input  wire logic            o_op_ready,
  input  wire logic            o_done,
  input  wire logic            o_skip,
  input  wire logic            o_taken,
  input  wire logic [PC_W-1:0] o_pc,
  input  wire logic [7:0]      o_flags,
  input  wire logic            o_waitrequest
);
  import csb_pkg::*;
  logic tk;
  logic is_cmp;
  logic is_skip;
  logic is_br;
  assign tk = i_op_valid && o_op_ready;
  assign is_cmp = i_op.code inside {[compare_regs:compare_immediate]};
  assign is_skip = i_op.code inside {[skip_if_reg_bit_clear:skip_if_io_bit_set]};
  assign is_br = i_op.code >= branch_if_status_bit_set;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_nrst);
  sequence s_one;
    o_done && o_op_ready;
  endsequence
  sequence s_two;
    !o_done && !o_op_ready ##1 o_done;
  endsequence
  sequence s_three;
    !o_done [*2] ##1 o_done;
  endsequence
  chk_cmp_one_cycle: assert property (tk && is_cmp |=> s_one)
    else $error("compare not done in one cycle");
  chk_cmp_pc_step: assert property (tk && is_cmp |=> o_pc == $past(o_pc) + 1'b1)
    else $error("compare pc step wrong");
  chk_skip_flags_kept: assert property (tk && is_skip |=> $stable(o_flags))
    else $error("skip changed flags");
  chk_branch_flags_kept: assert property (tk && is_br |=> $stable(o_flags))
    else $error("branch changed flags");
  chk_branch_cycle_count: assert property (tk && is_br
    |=> if (o_taken) s_two else s_one)
    else $error("branch cycle count wrong");
  chk_equal_on_zero: assert property (tk && i_op.code == branch_if_equal
    |=> o_taken == $past(o_flags[FLAG_Z]))
    else $error("equal branch decision wrong");
  chk_not_equal_zero: assert property (tk && i_op.code == branch_if_not_equal
    |=> o_taken != $past(o_flags[FLAG_Z]))
    else $error("not equal branch decision wrong");
  chk_signed_ge_rule: assert property (tk && i_op.code == branch_if_signed_ge
    |=> o_taken != ($past(o_flags[FLAG_N]) ^ $past(o_flags[FLAG_V])))
    else $error("signed ge decision wrong");
  chk_skip_long_wait: assert property (tk && is_skip && i_op.next_two_word
    |=> o_skip |-> s_three)
    else $error("two word skip timing wrong");
  chk_skip_short_wait: assert property (tk && is_skip && !i_op.next_two_word
    |=> o_skip |-> s_two)
    else $error("one word skip timing wrong");
  chk_bus_wait_one: assert property ($fell(o_waitrequest) |=> o_waitrequest)
    else $error("waitrequest low too long");
endmodule
bind compare_skip_branch_unit csb_assertions #(.PC_W(PC_W)) chk_i (.i_mclk(i_mclk),
  .i_nrst(i_nrst), .i_op_valid(i_op_valid), .i_op(i_op), .o_op_ready(o_op_ready),
  .o_done(o_done), .o_skip(o_skip), .o_taken(o_taken), .o_pc(o_pc), .o_flags(o_flags),
  .o_waitrequest(o_waitrequest));
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import csb_pkg::*;
  typedef struct packed {
    opcode_t    c;
    logic [7:0] a;
    logic [7:0] b;
    logic [2:0] s;
    logic       w;
    logic [7:0] pre;
    logic [8:0] pc;
    logic [7:0] fl;
    logic [1:0] cy;
  } row_t;
  logic        i_mclk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_op_valid = 1'b0;
  op_t         i_op = '0;
  logic [3:0]  i_address = 4'h0;
  logic        i_read = 1'b0;
  logic        i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0]  i_byteenable = 4'h0;
  logic        o_op_ready, o_done, o_skip, o_taken, o_waitrequest;
  logic [8:0]  o_pc;
  logic [7:0]  o_flags;
  logic [31:0] o_readdata, q;
  int          failures = 0;
  int          n_checks = 0;
  int          n;
  op_t         op;
  logic [7:0]  f;
  logic [9:0]  e;
  logic        t;
  localparam logic [17:0] INV = 18'h2a66a;
  int idx [18] = '{9, 9, FLAG_Z, FLAG_Z, FLAG_C, FLAG_C, FLAG_C, FLAG_C, FLAG_N, FLAG_N,
                   8, 8, FLAG_H, FLAG_H, FLAG_T, FLAG_T, FLAG_V, FLAG_V};
  logic [7:0] pats [4] = '{8'h00, 8'hff, 8'h55, 8'haa};
  row_t rows [10] = '{
    '{compare_regs, 8'h10, 8'h10, 3'h0, 1'b0, 8'hd0, 9'h011, 8'hd2, 2'h1},
    '{compare_regs, 8'h00, 8'h01, 3'h0, 1'b0, 8'hd0, 9'h011, 8'hf5, 2'h1},
    '{compare_regs, 8'h80, 8'h01, 3'h0, 1'b0, 8'hd0, 9'h011, 8'hf8, 2'h1},
    '{compare_regs_with_carry, 8'h05, 8'h05, 3'h0, 1'b0, 8'hd1, 9'h011, 8'hf5, 2'h1},
    '{compare_immediate, 8'h7f, 8'h80, 3'h0, 1'b0, 8'hd0, 9'h011, 8'hdd, 2'h1},
    '{skip_if_reg_bit_clear, 8'hfb, 8'h00, 3'h2, 1'b0, 8'h5a, 9'h012, 8'h5a, 2'h2},
    '{skip_if_reg_bit_set, 8'h80, 8'h00, 3'h7, 1'b1, 8'h5a, 9'h013, 8'h5a, 2'h3},
    '{skip_if_reg_bit_set, 8'h7f, 8'h00, 3'h7, 1'b0, 8'h5a, 9'h011, 8'h5a, 2'h1},
    '{skip_if_io_bit_clear, 8'hfe, 8'h00, 3'h0, 1'b0, 8'h5a, 9'h012, 8'h5a, 2'h2},
    '{skip_if_io_bit_set, 8'h01, 8'h00, 3'h0, 1'b1, 8'h5a, 9'h013, 8'h5a, 2'h3}};

  compare_skip_branch_unit #(.PC_W(9)) dut (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_op_valid(i_op_valid), .i_op(i_op), .o_op_ready(o_op_ready), .o_done(o_done),
    .o_skip(o_skip), .o_taken(o_taken), .o_pc(o_pc), .o_flags(o_flags),
    .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest));

  always #5 i_mclk = ~i_mclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic [3:0] a, input logic rd, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge i_mclk);
    i_address <= a;
    i_read <= rd;
    i_write <= !rd;
    i_writedata <= d;
    i_byteenable <= be;
    do @(posedge i_mclk); while (o_waitrequest !== 1'b0);
    q = o_readdata;
    i_read <= 1'b0;
    i_write <= 1'b0;
  endtask

  task automatic setup(input logic [7:0] fl);
    bus(OFS_FLAGS, 1'b0, {24'h0, fl}, 4'h1);
    bus(OFS_PC, 1'b0, 32'h10, 4'hf);
  endtask

  task automatic do_op(input op_t o);
    n = 0;
    @(posedge i_mclk);
    while (o_op_ready !== 1'b1) @(posedge i_mclk);
    i_op <= o;
    i_op_valid <= 1'b1;
    @(posedge i_mclk);
    i_op_valid <= 1'b0;
    do
    begin
      @(posedge i_mclk);
      n++;
    end while (o_done !== 1'b1 && n < 8);
  endtask

  task report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge i_mclk);
    failures++;
    report_and_stop;
  end

  initial
  begin
    repeat (2) @(posedge i_mclk);
    chk({o_op_ready, o_waitrequest, o_pc, o_flags}, 32'h20000);
    i_nrst <= 1'b1;
    $display("reset values done");
    foreach (rows[i])
    begin
      op = '0;
      op.code = rows[i].c;
      op.io_value = rows[i].a;
      op.first = (rows[i].c inside {skip_if_io_bit_clear, skip_if_io_bit_set}) ? ~rows[i].a
                                                                          : rows[i].a;
      op.second = (rows[i].c == compare_immediate) ? ~rows[i].b : rows[i].b;
      op.immediate = rows[i].b;
      op.bit_sel = rows[i].s;
      op.next_two_word = rows[i].w;
      setup(rows[i].pre);
      do_op(op);
      chk(o_pc, rows[i].pc);
      chk(o_flags, rows[i].fl);
      chk(n, rows[i].cy);
      chk(o_skip, rows[i].pc > 9'h011);
    end
    bus(OFS_DIFF, 1'b1, 32'h0, 4'hf);
    chk(q, 32'hff);
    $display("compare and skip rows done");
    for (int i = 0; i < 18; i++)
      for (int j = 0; j < 4; j++)
      begin
        f = pats[j];
        op = '0;
        op.code = opcode_t'(5'(i + 8));
        op.bit_sel = 3'(i + j * 3);
        op.offset = j[0] ? 7'h7e : 7'h05;
        e = {f[op.bit_sel], f[FLAG_N] ^ f[FLAG_V], f};
        t = e[idx[i]] ^ INV[i];
        setup(f);
        do_op(op);
        chk(o_taken, t);
        chk(o_flags, f);
        chk(o_pc, t ? (j[0] ? 9'h00f : 9'h016) : 9'h011);
        chk(n, t ? 2 : 1);
      end
    $display("branch sweep done");
    setup(8'h5a);
    bus(OFS_FLAGS, 1'b0, 32'hff, 4'h0);
    chk(o_flags, 8'h5a);
    bus(OFS_FLAGS, 1'b1, 32'h0, 4'hf);
    chk(q, 32'h5a);
    bus(4'h1, 1'b1, 32'h0, 4'hf);
    chk(q, 32'h0);
    op = '0;
    op.code = branch_if_equal;
    op.offset = 7'h05;
    do_op(op);
    bus(OFS_INFO, 1'b1, 32'h0, 4'hf);
    chk(q, 32'h0a);
    bus(OFS_PC, 1'b1, 32'h0, 4'hf);
    chk(q, 32'h16);
    $display("bus and info done");
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk({o_op_ready, o_waitrequest, o_done, o_skip, o_taken, o_pc, o_flags}, 32'h100000);
    chk(o_readdata, 32'h0);
    i_nrst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk(o_op_ready, 1'b1);
    op = '0;
    op.code = compare_regs;
    op.first = 8'h21;
    op.second = 8'h21;
    do_op(op);
    chk(o_flags, 8'h02);
    chk(o_pc, 9'h001);
    $display("second reset done");
    report_and_stop;
  end
endmodule
`default_nettype wire
